// ---- hdl/adcsi_defines.svh ----
// Register addresses, field positions, reset values and timing counts
`ifndef ADCSI_DEFINES_SVH
`define ADCSI_DEFINES_SVH

// Register addresses
`define ADCSI_ADDR_STA   32'hFFFF0500
`define ADCSI_ADDR_MSK   32'hFFFF0504
`define ADCSI_ADDR_MDE   32'hFFFF0508
`define ADCSI_ADDR_CFG   32'hFFFF0510
`define ADCSI_ADDR_GAIN  32'hFFFF0514
`define ADCSI_ADDR_CUR   32'hFFFF0520
`define ADCSI_ADDR_VLT   32'hFFFF0524
`define ADCSI_ADDR_TMP   32'hFFFF0528
`define ADCSI_ADDR_THR   32'hFFFF0530
`define ADCSI_ADDR_TCL   32'hFFFF0534
`define ADCSI_ADDR_THV   32'hFFFF0538

// Reset values
`define ADCSI_RST_WORD   16'h0000
`define ADCSI_RST_BYTE   8'h00

// Configuration fields
`define ADCSI_CFG_OVR_EN 2
`define ADCSI_CFG_CMP_EN 3
`define ADCSI_CFG_TCN_EN 4

// Clamp values
`define ADCSI_POS_FS     16'h7FFF
`define ADCSI_NEG_FS     16'h8000

// Overrange re-evaluation period
`define ADCSI_CLK_PERIOD_NS 8
`define ADCSI_OVR_PERIOD_NS 125000
`define ADCSI_OVR_CYC (`ADCSI_OVR_PERIOD_NS / `ADCSI_CLK_PERIOD_NS)

`endif

// ---- hdl/adcsi_pkg.sv ----
// Types shared by the converter status and interrupt logic
package adcsi_pkg;
    typedef logic [15:0] adcsi_word_t;
    typedef logic [7:0]  adcsi_byte_t;
    typedef enum logic [1:0] {
        ADCSI_RNG_OK    = 2'b00,
        ADCSI_RNG_UNDER = 2'b01,
        ADCSI_RNG_OVER  = 2'b11
    } adcsi_range_t;
endpackage : adcsi_pkg

// ---- hdl/adcsi_chan_if.sv ----
// Signals between the control logic and one result holder
`timescale 1ns/1ps
interface adcsi_chan_if;
    logic        conv_valid;
    logic [15:0] conv_data;
    logic        conv_ovr;
    logic        conv_und;
    logic        clr_rdy;
    logic        cal_set;
    logic        core_pd;
    logic [15:0] result;
    logic        rdy;
    logic        err;
    logic        wrote;
    modport hold (input conv_valid, conv_data, conv_ovr, conv_und, clr_rdy,
                  cal_set, core_pd, output result, rdy, err, wrote);
    modport ctrl (output conv_valid, conv_data, conv_ovr, conv_und, clr_rdy,
                  cal_set, core_pd, input result, rdy, err, wrote);
endinterface : adcsi_chan_if

// ---- hdl/adcsi_result_hold.sv ----
// One channel result register with ready and range error flags
`timescale 1ns/1ps
`include "adcsi_defines.svh"
module adcsi_result_hold (
    input  wire logic  core_clk_i, // System clock
    input  wire logic  nrst_i,     // Sync reset, active low
    adcsi_chan_if.hold ch          // Channel signals
);
    import adcsi_pkg::*;

    logic         allowed;
    adcsi_range_t rng;
    adcsi_word_t  next_result;

    // Replace only when ready is clear, being cleared, or core asleep
    assign allowed  = !ch.rdy || ch.clr_rdy || ch.core_pd; // R7 R8
    assign ch.wrote = ch.conv_valid && allowed;

    // Range class of the incoming conversion
    always_comb begin
        rng = ADCSI_RNG_OK;
        if (ch.conv_ovr) begin
            rng = ADCSI_RNG_OVER;
        end else if (ch.conv_und) begin
            rng = ADCSI_RNG_UNDER;
        end
    end

    // Clamp out-of-range results to full scale
    always_comb begin
        case (rng)
            ADCSI_RNG_OVER:  next_result = `ADCSI_POS_FS; // R14
            ADCSI_RNG_UNDER: next_result = `ADCSI_NEG_FS; // R14
            default:         next_result = ch.conv_data;
        endcase
    end

    // Result register
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ch.result <= `ADCSI_RST_WORD;
        end else if (ch.wrote) begin
            ch.result <= next_result; // R7 R8
        end
    end

    // Ready flag, set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ch.rdy <= 1'b0;
        end else if (ch.wrote || ch.cal_set) begin
            ch.rdy <= 1'b1; // R22
        end else if (ch.clr_rdy) begin
            ch.rdy <= 1'b0;
        end
    end

    // Range error flag
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ch.err <= 1'b0;
        end else if (ch.conv_valid && rng != ADCSI_RNG_OK) begin
            ch.err <= 1'b1; // R11 R12 R13
        end else if (ch.wrote) begin
            ch.err <= 1'b0; // R11 R12 R13
        end
    end

    // Checks on update gating and clamping
    property p_no_overwrite;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ch.rdy && !ch.clr_rdy && !ch.core_pd |=> $stable(ch.result);
    endproperty
    a_no_overwrite: assert property (p_no_overwrite) // R7
        else $error("result overwritten while ready set");

    property p_clamp_over;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ch.wrote && ch.conv_ovr |=> ch.result == 16'h7FFF;
    endproperty
    a_clamp_over: assert property (p_clamp_over) // R14
        else $error("overrange result not clamped");

    property p_clamp_under;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ch.wrote && !ch.conv_ovr && ch.conv_und |=> ch.result == 16'h8000;
    endproperty
    a_clamp_under: assert property (p_clamp_under) // R14
        else $error("underrange result not clamped");

    property p_pd_update;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ch.conv_valid && ch.core_pd && !ch.conv_ovr && !ch.conv_und
            |=> ch.result == $past(ch.conv_data);
    endproperty
    a_pd_update: assert property (p_pd_update) // R8
        else $error("result not updated while core powered down");

    property p_err_clear;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ch.err && ch.wrote && !ch.conv_ovr && !ch.conv_und |=> !ch.err;
    endproperty
    a_err_clear: assert property (p_err_clear) // R13
        else $error("error flag kept after in-range result");
endmodule : adcsi_result_hold

// ---- hdl/adcsi_top.sv ----
// Converter status, interrupt and result-update control
//
// Notes on behaviour
// R1: Status upper byte never drives interrupt
// R2: Status low byte ORed into one interrupt
// R3: Each low-byte source masked individually
// R4: Current result read clears all ready
// R5: Current channel off: other reads clear ready
// R6: Software reads voltage before current result
// R7: No result overwrite while ready set
// R8: Core powered down: results always update
// R9: Status read-only, zero after reset
// R10: Bit 15 set on calibration, mode write clears
// R11: Bit 14 temperature range error flag
// R12: Bit 13 voltage range error flag
// R13: Bit 12 current range error flag
// R14: Range errors clamp result to full scale
// R15: Status bits 11 to 5 reserved
// R16: Bit 4 set when magnitude exceeds threshold
// R17: Threshold counter gates bit 4 by count
// R18: Bit 3 set on gross current overrange
// R19: Bit 3 re-evaluated every 125 us
// R20: Bit 3 sticky until disable or gain write
// R21: Mask resets zero, one enables source
// R22: Ready bit 0 set on result, calibration
// R23: Interrupt is a level while sources pending
`timescale 1ns/1ps
`include "adcsi_defines.svh"
module adcsi_top #(
    parameter int unsigned OVR_PERIOD_CYC = `ADCSI_OVR_CYC // Overrange period
) (
    input  wire logic                core_clk_i,  // System clock
    input  wire logic                nrst_i,      // Sync reset, active low
    input  wire logic [31:0]         mmr_addr_i,  // Register address
    input  wire logic                mmr_rd_i,    // Read strobe
    input  wire logic                mmr_wr_i,    // Write strobe
    input  wire adcsi_pkg::adcsi_word_t mmr_wdata_i, // Write data
    output adcsi_pkg::adcsi_word_t   mmr_rdata_o, // Read data
    input  wire logic                cur_valid_i, // Current result strobe
    input  wire adcsi_pkg::adcsi_word_t cur_data_i, // Current result
    input  wire logic                cur_ovr_i,   // Current overrange
    input  wire logic                cur_und_i,   // Current underrange
    input  wire logic                vlt_valid_i, // Voltage result strobe
    input  wire adcsi_pkg::adcsi_word_t vlt_data_i, // Voltage result
    input  wire logic                vlt_ovr_i,   // Voltage overrange
    input  wire logic                vlt_und_i,   // Voltage underrange
    input  wire logic                tmp_valid_i, // Temperature strobe
    input  wire adcsi_pkg::adcsi_word_t tmp_data_i, // Temperature result
    input  wire logic                tmp_ovr_i,   // Temperature overrange
    input  wire logic                tmp_und_i,   // Temperature underrange
    input  wire logic                cal_done_i,  // Calibration finished
    input  wire logic                core_pd_i,   // Core powered down
    input  wire logic                cur_adc_en_i, // Current channel on
    input  wire logic                gross_ovr_i, // Analog gross overrange
    output logic                     irq_o        // Converter interrupt
);
    import adcsi_pkg::*;

    localparam int CW = $clog2(OVR_PERIOD_CYC);

    adcsi_chan_if cur_ch ();
    adcsi_chan_if vlt_ch ();
    adcsi_chan_if tmp_ch ();

    adcsi_byte_t    mask;
    adcsi_byte_t    mode;
    adcsi_byte_t    cfg;
    adcsi_byte_t    gain;
    adcsi_word_t    thresh;
    adcsi_word_t    tcl;
    adcsi_word_t    thv;
    adcsi_word_t    status_word;
    adcsi_word_t    next_rdata;
    adcsi_word_t    cur_mag;
    logic           cal_flag;
    logic           cmp_flag;
    logic           ovr_flag;
    logic           cmp_go;
    logic           over_thr;
    logic           cmp_hit;
    logic           gross_s1;
    logic           gross_s2;
    logic [CW-1:0]  ovr_cnt;
    logic           ovr_tick;
    logic           clr_all;
    logic           rd_cur;
    logic           rd_vlt;
    logic           rd_tmp;
    logic           wr_msk;
    logic           wr_mde;
    logic           wr_cfg;
    logic           wr_gain;
    logic           wr_thr;
    logic           wr_tcl;
    logic           cmp_en;
    logic           tcn_en;
    logic           ovr_en;

    // Access strobes; status and result registers take no writes
    assign rd_cur  = mmr_rd_i && (mmr_addr_i == `ADCSI_ADDR_CUR);
    assign rd_vlt  = mmr_rd_i && (mmr_addr_i == `ADCSI_ADDR_VLT);
    assign rd_tmp  = mmr_rd_i && (mmr_addr_i == `ADCSI_ADDR_TMP);
    assign wr_msk  = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_MSK);
    assign wr_mde  = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_MDE);
    assign wr_cfg  = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_CFG);
    assign wr_gain = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_GAIN);
    assign wr_thr  = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_THR);
    assign wr_tcl  = mmr_wr_i && (mmr_addr_i == `ADCSI_ADDR_TCL);

    assign cmp_en = cfg[`ADCSI_CFG_CMP_EN];
    assign tcn_en = cfg[`ADCSI_CFG_TCN_EN];
    assign ovr_en = cfg[`ADCSI_CFG_OVR_EN];

    // Ready clear on result reads
    assign clr_all = rd_cur                                   // R4
                   || (!cur_adc_en_i && (rd_vlt || rd_tmp));  // R5

    // Channel hookup
    assign cur_ch.conv_valid = cur_valid_i;
    assign cur_ch.conv_data  = cur_data_i;
    assign cur_ch.conv_ovr   = cur_ovr_i;
    assign cur_ch.conv_und   = cur_und_i;
    assign vlt_ch.conv_valid = vlt_valid_i;
    assign vlt_ch.conv_data  = vlt_data_i;
    assign vlt_ch.conv_ovr   = vlt_ovr_i;
    assign vlt_ch.conv_und   = vlt_und_i;
    assign tmp_ch.conv_valid = tmp_valid_i;
    assign tmp_ch.conv_data  = tmp_data_i;
    assign tmp_ch.conv_ovr   = tmp_ovr_i;
    assign tmp_ch.conv_und   = tmp_und_i;
    assign cur_ch.clr_rdy    = clr_all;
    assign vlt_ch.clr_rdy    = clr_all || rd_vlt;
    assign tmp_ch.clr_rdy    = clr_all || rd_tmp;
    assign cur_ch.cal_set    = cal_done_i;
    assign vlt_ch.cal_set    = cal_done_i;
    assign tmp_ch.cal_set    = cal_done_i;
    assign cur_ch.core_pd    = core_pd_i;
    assign vlt_ch.core_pd    = core_pd_i;
    assign tmp_ch.core_pd    = core_pd_i;

    // Result holders
    adcsi_result_hold u_cur (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ch         (cur_ch.hold)
    );
    adcsi_result_hold u_vlt (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ch         (vlt_ch.hold)
    );
    adcsi_result_hold u_tmp (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .ch         (tmp_ch.hold)
    );

    // Writable control registers
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mask   <= `ADCSI_RST_BYTE; // R21
            mode   <= `ADCSI_RST_BYTE;
            cfg    <= `ADCSI_RST_BYTE;
            gain   <= `ADCSI_RST_BYTE;
            thresh <= `ADCSI_RST_WORD;
            tcl    <= `ADCSI_RST_WORD;
        end else begin
            if (wr_msk) begin
                mask <= mmr_wdata_i[7:0];
            end
            if (wr_mde) begin
                mode <= mmr_wdata_i[7:0];
            end
            if (wr_cfg) begin
                cfg <= mmr_wdata_i[7:0];
            end
            if (wr_gain) begin
                gain <= mmr_wdata_i[7:0];
            end
            if (wr_thr) begin
                thresh <= mmr_wdata_i;
            end
            if (wr_tcl) begin
                tcl <= mmr_wdata_i;
            end
        end
    end

    // Calibration done flag, set wins over mode write
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cal_flag <= 1'b0;
        end else if (cal_done_i) begin
            cal_flag <= 1'b1; // R10
        end else if (wr_mde) begin
            cal_flag <= 1'b0; // R10
        end
    end

    // Comparator runs one cycle after a current result lands
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cmp_go <= 1'b0;
        end else begin
            cmp_go <= cur_ch.wrote;
        end
    end

    assign cur_mag  = cur_ch.result[15] ? 16'(~cur_ch.result + 16'h0001)
                                        : cur_ch.result;
    assign over_thr = cmp_go && cmp_en && (cur_mag > thresh); // R16
    assign cmp_hit  = over_thr
                    && (!tcn_en || (16'(thv + 16'h0001) == tcl)); // R17

    // Over-threshold conversion counter
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            thv <= `ADCSI_RST_WORD;
        end else if (!cmp_en || !tcn_en) begin
            thv <= `ADCSI_RST_WORD;
        end else if (cmp_go) begin
            thv <= over_thr ? 16'(thv + 16'h0001) : `ADCSI_RST_WORD; // R17
        end
    end

    // Threshold flag, dropped when comparator is disabled
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cmp_flag <= 1'b0;
        end else if (cmp_hit) begin
            cmp_flag <= 1'b1; // R16 R17
        end else if (!cmp_en) begin
            cmp_flag <= 1'b0;
        end
    end

    // Gross overrange input synchroniser
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            gross_s1 <= 1'b0;
            gross_s2 <= 1'b0;
        end else begin
            gross_s1 <= gross_ovr_i;
            gross_s2 <= gross_s1;
        end
    end

    // Overrange evaluation period
    assign ovr_tick = (ovr_cnt == CW'(OVR_PERIOD_CYC - 1));

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ovr_cnt <= '0;
        end else if (ovr_tick) begin
            ovr_cnt <= '0; // R19
        end else begin
            ovr_cnt <= CW'(ovr_cnt + 1'b1);
        end
    end

    // Overrange flag, sticky until disable or gain write
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ovr_flag <= 1'b0;
        end else if (ovr_tick && ovr_en && gross_s2) begin
            ovr_flag <= 1'b1; // R18 R19
        end else if (!ovr_en || wr_gain) begin
            ovr_flag <= 1'b0; // R20
        end
    end

    // Status word; reserved bits read zero
    assign status_word = {cal_flag, tmp_ch.err, vlt_ch.err, cur_ch.err,
                          7'h00,                                 // R15
                          cmp_flag, ovr_flag,
                          tmp_ch.rdy, vlt_ch.rdy, cur_ch.rdy};   // R9

    // Only the low byte, masked, forms the interrupt level
    assign irq_o = |(status_word[7:0] & mask); // R1 R2 R3 R23

    // Read data select
    always_comb begin
        next_rdata = `ADCSI_RST_WORD;
        if (mmr_addr_i == `ADCSI_ADDR_STA) begin
            next_rdata = status_word;
        end else if (mmr_addr_i == `ADCSI_ADDR_MSK) begin
            next_rdata = {8'h00, mask};
        end else if (mmr_addr_i == `ADCSI_ADDR_MDE) begin
            next_rdata = {8'h00, mode};
        end else if (mmr_addr_i == `ADCSI_ADDR_CFG) begin
            next_rdata = {8'h00, cfg};
        end else if (mmr_addr_i == `ADCSI_ADDR_GAIN) begin
            next_rdata = {8'h00, gain};
        end else if (mmr_addr_i == `ADCSI_ADDR_CUR) begin
            next_rdata = cur_ch.result;
        end else if (mmr_addr_i == `ADCSI_ADDR_VLT) begin
            next_rdata = vlt_ch.result;
        end else if (mmr_addr_i == `ADCSI_ADDR_TMP) begin
            next_rdata = tmp_ch.result;
        end else if (mmr_addr_i == `ADCSI_ADDR_THR) begin
            next_rdata = thresh;
        end else if (mmr_addr_i == `ADCSI_ADDR_TCL) begin
            next_rdata = tcl;
        end else if (mmr_addr_i == `ADCSI_ADDR_THV) begin
            next_rdata = thv;
        end
    end

    // Read data register
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            mmr_rdata_o <= `ADCSI_RST_WORD;
        end else if (mmr_rd_i) begin
            mmr_rdata_o <= next_rdata;
        end
    end

    // Checks on status, clearing and interrupt behaviour
    sequence s_quiet;
        !cur_valid_i && !vlt_valid_i && !tmp_valid_i && !cal_done_i;
    endsequence

    sequence s_rd_cur;
        mmr_rd_i && mmr_addr_i == 32'hFFFF0520 ##0 s_quiet;
    endsequence

    sequence s_rd_other;
        mmr_rd_i && !cur_adc_en_i
            && (mmr_addr_i == 32'hFFFF0524 || mmr_addr_i == 32'hFFFF0528)
            ##0 s_quiet;
    endsequence

    property p_rd_cur_clears;
        @(posedge core_clk_i) disable iff (!nrst_i)
        s_rd_cur |=> status_word[2:0] == 3'h0;
    endproperty
    a_rd_cur_clears: assert property (p_rd_cur_clears) // R4
        else $error("ready bits not cleared by current read");

    property p_rd_other_clears;
        @(posedge core_clk_i) disable iff (!nrst_i)
        s_rd_other |=> status_word[2:0] == 3'h0;
    endproperty
    a_rd_other_clears: assert property (p_rd_other_clears) // R5
        else $error("ready bits not cleared with current channel off");

    property p_upper_no_irq;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (status_word[7:0] & mask) == 8'h00 |-> !irq_o;
    endproperty
    a_upper_no_irq: assert property (p_upper_no_irq) // R1
        else $error("interrupt without pending low-byte source");

    property p_irq_level;
        @(posedge core_clk_i) disable iff (!nrst_i)
        cur_ch.rdy && mask[0] ##1 cur_ch.rdy && mask[0] |-> irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) // R23
        else $error("interrupt dropped while source pending");

    property p_mode_clears_cal;
        @(posedge core_clk_i) disable iff (!nrst_i)
        wr_mde && !cal_done_i |=> !status_word[15] ##1 !status_word[15]
            or cal_done_i;
    endproperty
    a_mode_clears_cal: assert property (p_mode_clears_cal) // R10
        else $error("calibration flag not cleared by mode write");

    property p_ovr_on_tick;
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(ovr_flag) |-> $past(ovr_tick) && $past(gross_s2);
    endproperty
    a_ovr_on_tick: assert property (p_ovr_on_tick) // R19
        else $error("overrange flag set off the evaluation period");

    property p_ovr_sticky;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ovr_flag && ovr_en && !wr_gain |=> ovr_flag;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) // R20
        else $error("overrange flag lost while enabled");

    property p_status_ro;
        @(posedge core_clk_i) disable iff (!nrst_i)
        mmr_wr_i && mmr_addr_i == 32'hFFFF0500 && !cal_done_i
            && !cur_valid_i && !vlt_valid_i && !tmp_valid_i && !cmp_go
            && !ovr_tick && cfg == 8'h00
            |=> status_word == $past(status_word);
    endproperty
    a_status_ro: assert property (p_status_ro) // R9
        else $error("status word changed by a bus write");
endmodule : adcsi_top

// ---- tb/adcsi_core_model.sv ----
// Processor core model issuing register reads and writes
`timescale 1ns/1ps
module adcsi_core_model (
    input  wire logic                   core_clk_i, // System clock
    input  wire adcsi_pkg::adcsi_word_t rdata_i,    // Read data
    output logic [31:0]                 addr_o,     // Register address
    output logic                        rd_o,       // Read strobe
    output logic                        wr_o,       // Write strobe
    output adcsi_pkg::adcsi_word_t      wdata_o     // Write data
);
    import adcsi_pkg::*;
    // Idle bus at time zero
    initial begin
        addr_o = 32'h0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        wdata_o = 16'h0;
    end
    // One write pulse, then one idle cycle
    task automatic wr(input logic [31:0] a, input adcsi_word_t d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge core_clk_i);
        #1 wr_o = 1'b0;
        wdata_o = ~d;
        @(posedge core_clk_i);
        #1;
    endtask : wr
    // One read pulse; data taken after the answering edge
    task automatic rd(input logic [31:0] a, output adcsi_word_t d);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge core_clk_i);
        #1 rd_o = 1'b0;
        d = rdata_i;
        @(posedge core_clk_i);
        #1;
    endtask : rd
endmodule : adcsi_core_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter status and interrupt logic
`timescale 1ns/1ps
`include "adcsi_defines.svh"
module testbench;
    import adcsi_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [31:0] a;
    logic        r, w, irq;
    adcsi_word_t wd, rdat, v;
    logic [2:0]  vld = 3'b0, ovr = 3'b0, und = 3'b0;
    adcsi_word_t dat [3] = '{16'h0, 16'h0, 16'h0};
    logic        cal = 1'b0, pd = 1'b0, cen = 1'b1, gross = 1'b0;
    int          err_total = 0, checks = 0, cyc = 0;
    // Clock at 125 MHz
    always #4 core_clk_i = ~core_clk_i;
    adcsi_core_model u_adcsi_core_model (.core_clk_i(core_clk_i),
        .rdata_i(rdat), .addr_o(a), .rd_o(r), .wr_o(w), .wdata_o(wd));
    adcsi_top #(.OVR_PERIOD_CYC(16)) u_adcsi_top (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .mmr_addr_i(a), .mmr_rd_i(r), .mmr_wr_i(w),
        .mmr_wdata_i(wd), .mmr_rdata_o(rdat), .cur_valid_i(vld[0]),
        .cur_data_i(dat[0]), .cur_ovr_i(ovr[0]), .cur_und_i(und[0]),
        .vlt_valid_i(vld[1]), .vlt_data_i(dat[1]), .vlt_ovr_i(ovr[1]),
        .vlt_und_i(und[1]), .tmp_valid_i(vld[2]), .tmp_data_i(dat[2]),
        .tmp_ovr_i(ovr[2]), .tmp_und_i(und[2]), .cal_done_i(cal),
        .core_pd_i(pd), .cur_adc_en_i(cen), .gross_ovr_i(gross), .irq_o(irq));
    // Compare and count
    task automatic chk(input string n, input adcsi_word_t e, adcsi_word_t g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Read a register and compare
    task automatic rdc(input logic [31:0] ad, input adcsi_word_t e);
        u_adcsi_core_model.rd(ad, v);
        chk($sformatf("reg %h", ad), e, v);
    endtask : rdc
    // One conversion strobe on channel c
    task automatic conv(input int c, adcsi_word_t d, logic o, logic u);
        vld[c] = 1'b1;
        dat[c] = d;
        ovr[c] = o;
        und[c] = u;
        @(posedge core_clk_i);
        #1 vld[c] = 1'b0;
        dat[c] = ~d;
    endtask : conv
    // Counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    // Test sequence
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        rdc(`ADCSI_ADDR_STA, 16'h0000);
        chk("irq", 16'h0, {15'h0, irq});
        u_adcsi_core_model.wr(`ADCSI_ADDR_STA, 16'hFFFF);
        rdc(`ADCSI_ADDR_STA, 16'h0000);
        $display("test reset done");
        conv(0, 16'h1234, 1'b0, 1'b0);
        rdc(`ADCSI_ADDR_STA, 16'h0001);
        chk("irq", 16'h0, {15'h0, irq});
        u_adcsi_core_model.wr(`ADCSI_ADDR_MSK, 16'h0001);
        chk("irq", 16'h1, {15'h0, irq});
        conv(0, 16'h5555, 1'b0, 1'b0);
        conv(1, 16'h0222, 1'b0, 1'b0);
        rdc(`ADCSI_ADDR_VLT, 16'h0222);
        rdc(`ADCSI_ADDR_CUR, 16'h1234);
        rdc(`ADCSI_ADDR_STA, 16'h0000);
        chk("irq", 16'h0, {15'h0, irq});
        $display("test ready done");
        conv(1, 16'h0000, 1'b1, 1'b0);
        conv(2, 16'h0000, 1'b0, 1'b1);
        rdc(`ADCSI_ADDR_STA, 16'h6006);
        rdc(`ADCSI_ADDR_VLT, 16'h7FFF);
        rdc(`ADCSI_ADDR_TMP, 16'h8000);
        u_adcsi_core_model.wr(`ADCSI_ADDR_MSK, 16'h00FF);
        chk("irq", 16'h0, {15'h0, irq});
        conv(1, 16'h0010, 1'b0, 1'b0);
        rdc(`ADCSI_ADDR_STA, 16'h4002);
        chk("irq", 16'h1, {15'h0, irq});
        pd = 1'b1;
        conv(1, 16'h0020, 1'b0, 1'b0);
        pd = 1'b0;
        rdc(`ADCSI_ADDR_VLT, 16'h0020);
        $display("test range done");
        cal = 1'b1;
        @(posedge core_clk_i);
        #1 cal = 1'b0;
        rdc(`ADCSI_ADDR_STA, 16'hC007);
        u_adcsi_core_model.wr(`ADCSI_ADDR_MDE, 16'h0000);
        rdc(`ADCSI_ADDR_STA, 16'h4007);
        cen = 1'b0;
        rdc(`ADCSI_ADDR_TMP, 16'h8000);
        rdc(`ADCSI_ADDR_STA, 16'h4000);
        $display("test calibration done");
        u_adcsi_core_model.wr(`ADCSI_ADDR_CFG, 16'h0004);
        gross = 1'b1;
        repeat (40) @(posedge core_clk_i);
        #1 rdc(`ADCSI_ADDR_STA, 16'h4008);
        gross = 1'b0;
        repeat (40) @(posedge core_clk_i);
        #1 rdc(`ADCSI_ADDR_STA, 16'h4008);
        u_adcsi_core_model.wr(`ADCSI_ADDR_GAIN, 16'h0000);
        rdc(`ADCSI_ADDR_STA, 16'h4000);
        $display("test overrange done");
        u_adcsi_core_model.wr(`ADCSI_ADDR_THR, 16'h0100);
        u_adcsi_core_model.wr(`ADCSI_ADDR_TCL, 16'h0002);
        u_adcsi_core_model.wr(`ADCSI_ADDR_CFG, 16'h0018);
        conv(0, 16'hFE00, 1'b0, 1'b0);
        rdc(`ADCSI_ADDR_CUR, 16'hFE00);
        rdc(`ADCSI_ADDR_STA, 16'h4000);
        conv(0, 16'h0000, 1'b1, 1'b0);
        rdc(`ADCSI_ADDR_CUR, 16'h7FFF);
        rdc(`ADCSI_ADDR_STA, 16'h5010);
        chk("irq", 16'h1, {15'h0, irq});
        rdc(`ADCSI_ADDR_THV, 16'h0002);
        $display("test comparator done");
        test_done();
    end
endmodule : testbench
